// *** design/poe_serial_ctl.sv ***
`include "poe_map.svh"
module poe_serial_ctl import poe_pkg::*; #(
	parameter int NP = 4
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic scl_i,
	input wire logic serial_data_in_pin_i,
	output logic serial_data_out_pin_o,
	output logic serial_data_out_pin_oe_o,
	output logic int_n_o,
	output logic int_n_oe_o,
	input wire logic [3:0] address_select_pins_i,
	input wire logic [NP-1:0] det_ok_i,
	input wire logic [NP-1:0] load_gone_i,
	input wire logic [NP-1:0] startup_overcurrent_fault_i,
	input wire logic [NP-1:0] overload_timeout_fault_i,
	input wire logic pse_fault_i,
	output logic [NP-1:0] port_pwr_o
);
	// ======================================================================
	// bus condition detectors, clocked by the data line itself
	logic start_tog = 1'b0;
	logic stop_tog = 1'b0;
	always_ff @(negedge serial_data_in_pin_i) begin
		if (scl_i) begin
			start_tog <= ~start_tog;
		end
	end
	always_ff @(posedge serial_data_in_pin_i) begin
		if (scl_i) begin
			stop_tog <= ~stop_tog;
		end
	end

	// ======================================================================
	// link domain
	logic link_rst, int_seen;
	logic [3:0] ad_q;
	logic int_drive;
	poe_sync #(.W(6)) u_lsync (
		.clk_i(scl_i),
		.d_i({rst_i, int_drive, address_select_pins_i}),
		.q_o({link_rst, int_seen, ad_q})
	);

	poe_state_e st;
	logic [2:0] cnt;
	logic [6:0] sh;
	logic [7:0] txb, wr_data;
	logic [4:0] ptr, wr_addr;
	logic rw_rd, is_ara, wr_tog, ara_tog, start_seen, stop_seen, sda_oe;
	logic [47:0] img;

	// decode of the byte on the wire
	wire sda = serial_data_in_pin_i;
	wire start_pend = start_tog ^ start_seen;
	wire stop_pend = stop_tog ^ stop_seen;
	wire [6:0] own_addr = {`POE_ADDR_BASE, ad_q};
	wire [7:0] rx_byte = {sh, sda};
	wire own_hit = rx_byte[7:1] == own_addr;
	wire glob_hit = rx_byte[7:1] == `POE_ADDR_GLOBAL && !rx_byte[0];
	wire ara_hit = rx_byte == {`POE_ADDR_ARA, 1'b1} && int_seen;
	wire tx_bit = txb[~cnt];
	wire arb_lost = is_ara && tx_bit && !sda;

	// read selection from the frozen image
	wire [7:0] rd_byte =
		(ptr == `POE_REG_SUMMARY) ? img[7:0] :
		(ptr == `POE_REG_EVENT) ? img[15:8] :
		(ptr == `POE_REG_MASK) ? img[23:16] :
		(ptr == `POE_REG_MODE) ? img[31:24] :
		(ptr == `POE_REG_PWR) ? img[39:32] :
		(ptr == `POE_REG_LINE) ? img[47:40] : 8'h00;

	// bit engine: samples on the rising edge of the link clock
	always_ff @(posedge scl_i) begin
		if (link_rst) begin
			st <= ST_IDLE;
			cnt <= 3'h0;
			sh <= 7'h00;
			ptr <= 5'h00;
			txb <= 8'h00;
			rw_rd <= 1'b0;
			is_ara <= 1'b0;
			wr_tog <= 1'b0;
			ara_tog <= 1'b0;
			wr_addr <= 5'h00;
			wr_data <= 8'h00;
			start_seen <= start_tog;
			stop_seen <= stop_tog;
		end else if (start_pend) begin
			start_seen <= start_tog;
			stop_seen <= stop_tog;
			if (stop_pend) begin
				ptr <= 5'h00;
			end
			sh <= {6'h00, sda};
			cnt <= 3'h1;
			st <= ST_ADDR;
		end else begin
			cnt <= cnt + 3'h1;
			sh <= {sh[5:0], sda};
			case (st)
			ST_ADDR: begin
				if (cnt == 3'h7) begin
					rw_rd <= sda;
					is_ara <= ara_hit;
					st <= (own_hit || glob_hit || ara_hit) ? ST_ACK_A
						: ST_IDLE;
				end
			end
			ST_ACK_A: begin
				cnt <= 3'h0;
				st <= rw_rd ? ST_TX : ST_CMD;
				// pointer is zero after a stop
				txb <= is_ara ? {own_addr, 1'b1} : rd_byte;
			end
			ST_CMD: begin
				if (cnt == 3'h7) begin
					ptr <= rx_byte[4:0];
					st <= ST_ACK_C;
				end
			end
			ST_ACK_C: begin
				cnt <= 3'h0;
				st <= ST_DATA;
			end
			ST_DATA: begin
				if (cnt == 3'h7) begin
					wr_data <= rx_byte;
					wr_addr <= ptr;
					st <= ST_ACK_D;
				end
			end
			ST_ACK_D: begin
				wr_tog <= ~wr_tog;
				st <= ST_IDLE;
			end
			ST_TX: begin
				if (arb_lost) begin
					st <= ST_IDLE;
				end else if (cnt == 3'h7) begin
					st <= ST_TX_ACK;
					if (is_ara) begin
						ara_tog <= ~ara_tog;
					end
				end
			end
			ST_TX_ACK: begin
				// a nack ends the read
				cnt <= 3'h0;
				st <= (sda || is_ara) ? ST_IDLE : ST_TX;
				txb <= rd_byte;
			end
			default: st <= ST_IDLE;
			endcase
		end
	end

	// drive changes on the falling edge so data is stable while high
	wire next_oe = !start_pend && (st == ST_ACK_A || st == ST_ACK_C ||
		st == ST_ACK_D || (st == ST_TX && !tx_bit));
	always_ff @(negedge scl_i) begin
		if (link_rst) begin
			sda_oe <= 1'b0;
		end else begin
			sda_oe <= next_oe;
		end
	end
	assign serial_data_out_pin_oe_o = sda_oe;
	assign serial_data_out_pin_o = 1'b0;

	// ======================================================================
	// system domain: crossings from the link
	logic [3:0] tog_s, tog_d;
	poe_sync #(.W(4)) u_ssync (
		.clk_i(clk_sys_i),
		.d_i({start_tog, stop_tog, wr_tog, ara_tog}),
		.q_o(tog_s)
	);
	wire [3:0] tog_e = tog_s ^ tog_d;
	wire start_evt = tog_e[3];
	wire stop_evt = tog_e[2];
	wire wr_evt = tog_e[1];
	wire ara_evt = tog_e[0];

	// wr_addr and wr_data settle well before the toggle arrives
	wire we_evt = wr_evt && wr_addr == `POE_REG_EVENT;
	wire we_mask = wr_evt && wr_addr == `POE_REG_MASK;
	wire we_mode = wr_evt && wr_addr == `POE_REG_MODE;
	wire we_pwr = wr_evt && wr_addr == `POE_REG_PWR;
	wire we_line = wr_evt && wr_addr == `POE_REG_LINE;
	wire clr_all = we_line && wr_data[`POE_LINE_CLR_ALL];
	wire rel_req = we_line && wr_data[`POE_LINE_RELEASE];
	wire [7:0] clr = ({8{we_evt}} & wr_data) | {8{clr_all}};

	// ======================================================================
	// control registers and interrupt line
	logic busy, released;
	logic [7:0] mask, status;
	poe_mode_e mode;
	wire cause = |(status & mask);
	wire [7:0] line_rd = {6'h00, released, int_drive};

	poe_port_ctl #(.NP(NP)) u_port (
		.clk_i(clk_sys_i),
		.rst_i(rst_i),
		.mode_i(mode),
		.pwr_we_i(we_pwr),
		.data_i(wr_data),
		.clr_i(clr),
		.det_ok_i(det_ok_i),
		.load_gone_i(load_gone_i),
		.start_f_i(startup_overcurrent_fault_i),
		.icut_f_i(overload_timeout_fault_i),
		.pse_fault_i(pse_fault_i),
		.port_pwr_o(port_pwr_o),
		.status_o(status)
	);

	// bus-busy tracking and register writes
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			tog_d <= tog_s;
			busy <= 1'b0;
			mask <= `POE_MASK_RST;
			mode <= poe_mode_e'(`POE_MODE_RST);
		end else begin
			tog_d <= tog_s;
			busy <= start_evt | (busy & ~stop_evt);
			if (we_mask) begin
				mask <= wr_data;
			end
			if (we_mode) begin
				mode <= poe_mode_e'(wr_data[1:0]);
			end
		end
	end

	// release holds until the cause has gone; a new release wins
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			released <= 1'b0;
			int_drive <= 1'b0;
			img <= 48'h0;
		end else begin
			released <= ara_evt | rel_req | (released & cause);
			// line and readback only move while the bus is idle
			if (!busy) begin
				int_drive <= cause & ~released;
				img <= {line_rd, {(8-NP){1'b0}}, port_pwr_o, 6'h00, mode,
					mask, status, status & mask};
			end
		end
	end
	assign int_n_oe_o = int_drive;
	assign int_n_o = 1'b0;

	// ======================================================================
	// checks, link side
	property p_ptr_load;
		@(posedge scl_i) disable iff (link_rst)
		(st == ST_CMD && cnt == 3'h7 && !start_pend)
		|=> ptr == $past(rx_byte[4:0]);
	endproperty
	a_ptr_load: assert property (p_ptr_load)
		else $error("pointer not loaded from low command bits");
	property p_stop_clr;
		@(posedge scl_i) disable iff (link_rst)
		(start_pend && stop_pend) |=> ptr == 5'h00;
	endproperty
	a_stop_clr: assert property (p_stop_clr)
		else $error("pointer not cleared after stop");
	property p_ara_quiet;
		@(posedge scl_i) disable iff (link_rst)
		(st == ST_ADDR && cnt == 3'h7 && !start_pend && !int_seen &&
		rx_byte == {`POE_ADDR_ARA, 1'b1}) |=> st == ST_IDLE;
	endproperty
	a_ara_quiet: assert property (p_ara_quiet)
		else $error("alert address taken without interrupt");
	property p_ara_addr;
		@(posedge scl_i) disable iff (link_rst)
		(st == ST_ACK_A && is_ara && !start_pend)
		|=> txb == {`POE_ADDR_BASE, ad_q, 1'b1};
	endproperty
	a_ara_addr: assert property (p_ara_addr)
		else $error("alert reply is not own address");
	property p_arb;
		@(posedge scl_i) disable iff (link_rst)
		(st == ST_TX && arb_lost && !start_pend)
		|=> st == ST_IDLE && $stable(ara_tog);
	endproperty
	a_arb: assert property (p_arb)
		else $error("transmission went on after lost arbitration");
	property p_wr_pass;
		@(posedge scl_i) disable iff (link_rst)
		(st == ST_ACK_D && !start_pend) |=> wr_tog != $past(wr_tog);
	endproperty
	a_wr_pass: assert property (p_wr_pass)
		else $error("write data not handed over");

	// checks, system side
	property p_int_idle;
		@(posedge clk_sys_i) disable iff (rst_i)
		$changed(int_drive) |-> !$past(busy);
	endproperty
	a_int_idle: assert property (p_int_idle)
		else $error("interrupt line moved during a transaction");
	property p_released;
		@(posedge clk_sys_i) disable iff (rst_i)
		(released && !busy) |=> !int_drive;
	endproperty
	a_released: assert property (p_released)
		else $error("released interrupt line driven again");
endmodule : poe_serial_ctl

// *** design/poe_map.svh ***
`ifndef POE_MAP_SVH
`define POE_MAP_SVH
// ==========================================================================
// bus addresses
`define POE_ADDR_BASE 3'h2
`define POE_ADDR_GLOBAL 7'h30
`define POE_ADDR_ARA 7'h0C
// ==========================================================================
// register pointer values
`define POE_REG_SUMMARY 5'h00
`define POE_REG_EVENT 5'h01
`define POE_REG_MASK 5'h02
`define POE_REG_MODE 5'h03
`define POE_REG_PWR 5'h04
`define POE_REG_LINE 5'h1A
// ==========================================================================
// field positions
`define POE_LINE_CLR_ALL 7
`define POE_LINE_RELEASE 6
`define POE_EV_PSE_FAULT 7
`define POE_EV_START_FAULT 6
`define POE_EV_ICUT_FAULT 5
`define POE_EV_DISCONNECT 4
`define POE_EV_PWR_ON 3
`define POE_EV_CLASS_DONE 2
// ==========================================================================
// reset values
`define POE_MASK_RST 8'h00
`define POE_MODE_RST 2'h3
`endif

// *** design/poe_pkg.sv ***
package poe_pkg;
	// link-side protocol states, gray along the usual path
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ACK_A = 4'h3,
		ST_CMD = 4'h2,
		ST_ACK_C = 4'h6,
		ST_DATA = 4'h7,
		ST_ACK_D = 4'h5,
		ST_TX = 4'h4,
		ST_TX_ACK = 4'hC
	} poe_state_e;
	// operating modes
	typedef enum logic [1:0] {
		MODE_OFF = 2'h0,
		MODE_MANUAL = 2'h1,
		MODE_SEMI = 2'h2,
		MODE_AUTO = 2'h3
	} poe_mode_e;
endpackage : poe_pkg

// *** design/poe_sync.sv ***
module poe_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta;
	// two stages; only the second stage is seen by logic
	always_ff @(posedge clk_i) begin
		meta <= d_i;
		q_o <= meta;
	end
endmodule : poe_sync

// *** design/poe_port_ctl.sv ***
`include "poe_map.svh"
module poe_port_ctl import poe_pkg::*; #(
	parameter int NP = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire poe_mode_e mode_i,
	input wire logic pwr_we_i,
	input wire logic [7:0] data_i,
	input wire logic [7:0] clr_i,
	input wire logic [NP-1:0] det_ok_i,
	input wire logic [NP-1:0] load_gone_i,
	input wire logic [NP-1:0] start_f_i,
	input wire logic [NP-1:0] icut_f_i,
	input wire logic pse_fault_i,
	output logic [NP-1:0] port_pwr_o,
	output logic [7:0] status_o
);
	// ======================================================================
	// port power decisions
	logic [NP-1:0] on_cmd, off_cmd, auto_on, off_evt, next_pwr;
	logic [7:0] evt;
	assign on_cmd = pwr_we_i ? data_i[NP-1:0] : '0;
	assign off_cmd = pwr_we_i ? data_i[NP+3:4] : '0;
	assign auto_on = (mode_i == MODE_AUTO) ? det_ok_i : '0;
	assign off_evt = start_f_i | icut_f_i | load_gone_i;
	assign next_pwr = (mode_i == MODE_OFF) ? '0 :
		(port_pwr_o | on_cmd | auto_on) & ~off_evt & ~off_cmd;
	// ======================================================================
	// event sources; faults kept apart from disconnect
	always_comb begin
		evt = 8'h00;
		evt[`POE_EV_PSE_FAULT] = pse_fault_i;
		evt[`POE_EV_START_FAULT] = |(start_f_i & port_pwr_o);
		evt[`POE_EV_ICUT_FAULT] = |(icut_f_i & port_pwr_o);
		evt[`POE_EV_DISCONNECT] = |(load_gone_i & port_pwr_o);
		evt[`POE_EV_PWR_ON] = |(next_pwr & ~port_pwr_o);
		evt[`POE_EV_CLASS_DONE] = |det_ok_i;
	end
	// sticky bits: a new event wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_pwr_o <= '0;
			status_o <= 8'h00;
		end else begin
			port_pwr_o <= next_pwr;
			status_o <= (status_o & ~clr_i) | evt;
		end
	end
	// ======================================================================
	// checks
	property p_auto_on;
		@(posedge clk_i) disable iff (rst_i)
		(mode_i == MODE_AUTO && det_ok_i[0] && !off_evt[0] && !off_cmd[0])
		|=> port_pwr_o[0];
	endproperty
	a_auto_on: assert property (p_auto_on)
		else $error("auto mode did not power a detected port");
	property p_force_on;
		@(posedge clk_i) disable iff (rst_i)
		(pwr_we_i && data_i[0] && mode_i != MODE_OFF && !off_evt[0]
		&& !data_i[4]) |=> port_pwr_o[0];
	endproperty
	a_force_on: assert property (p_force_on)
		else $error("host power command ignored");
	property p_clear_all;
		@(posedge clk_i) disable iff (rst_i)
		(clr_i == 8'hFF && evt == 8'h00) |=> status_o == 8'h00;
	endproperty
	a_clear_all: assert property (p_clear_all)
		else $error("clear all left event bits set");
endmodule : poe_port_ctl

// *** verif/poe_host.sv ***
// ============================================================
// host bus master model
module poe_host (
	output logic scl_o,
	output logic sda_o,
	input wire logic sda_i
);
	timeunit 1ns;
	timeprecision 100ps;

	// both lines released while the bus is idle
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// one bus bit, data changes only while the clock is low
	task bit_cyc(input logic b, output logic r);
		sda_o = b;
		#3 scl_o = 1'b1;
		#3 r = sda_i;
		#3 scl_o = 1'b0;
		#3;
	endtask : bit_cyc

	// start or repeated start, clock held high around the data fall
	task start();
		sda_o = 1'b1;
		#3 scl_o = 1'b1;
		#6 sda_o = 1'b0;
		#6 scl_o = 1'b0;
		#3;
	endtask : start

	// stop, then idle long enough for register updates to land
	task stop();
		sda_o = 1'b0;
		#3 scl_o = 1'b1;
		#6 sda_o = 1'b1;
		#100;
	endtask : stop

	// only used around reset: data stays high, so no start is seen
	task idle(input int n);
		repeat (n) begin
			#6 scl_o = 1'b0;
			#6 scl_o = 1'b1;
		end
	endtask : idle

	// address or command byte, msb first; ack is the sampled low
	task send(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_cyc(b[i], r);
		bit_cyc(1'b1, r);
		ack = ~r;
	endtask : send

	// drv lets a competing responder pull bits low during alert reply
	task recv(input logic [7:0] drv, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_cyc(drv[i], d[i]);
		bit_cyc(1'b1, r); // single byte reads end in nack
	endtask : recv
endmodule : poe_host

// *** verif/poe_serial_ctl_bench.sv ***
// ============================================================
// bench top
module poe_serial_ctl_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic scl, h_sda, sda_w, sda_out, sda_oe, int_n, int_oe, power_sourcing_equipment;
	logic [3:0] det, gone, sta, ovl, pwr;
	// ack of a frame that is cut after its address byte
	logic mid_ack;
	int fail_count = 0;
	int check_count = 0;
	logic [16:0] tev [4] = '{17'h01000, 17'h10000, 17'h00020, 17'h00400};
	logic [7:0] tpw [4] = '{8'h06, 8'h06, 8'h04, 8'h00};
	logic [7:0] tsum [4] = '{8'h20, 8'hA0, 8'hB0, 8'hF0};

	always #4 clk_sys_i = ~clk_sys_i;
	// wired-and data line with pull-up
	assign sda_w = h_sda & (sda_oe ? sda_out : 1'b1);

	poe_host h (.scl_o(scl), .sda_o(h_sda), .sda_i(sda_w));

	poe_serial_ctl #(.NP(4)) dut (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl),
		.serial_data_in_pin_i(sda_w), .serial_data_out_pin_o(sda_out),
		.serial_data_out_pin_oe_o(sda_oe), .int_n_o(int_n),
		.int_n_oe_o(int_oe), .address_select_pins_i(4'h5),
		.det_ok_i(det), .load_gone_i(gone),
		.startup_overcurrent_fault_i(sta),
		.overload_timeout_fault_i(ovl), .pse_fault_i(power_sourcing_equipment),
		.port_pwr_o(pwr)
	);

	// ============================================================
	// helpers
	task check(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	task wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d);
		logic k;
		h.start();
		h.send({a, 1'b0}, k);
		check({7'h00, k}, 8'h01);
		h.send(c, k);
		h.send(d, k);
		check({7'h00, k}, 8'h01);
		h.stop();
	endtask : wr

	task rd(input logic [6:0] a, input logic [7:0] c, input logic [7:0] e);
		logic k;
		logic [7:0] d;
		h.start();
		h.send({a, 1'b0}, k);
		h.send(c, k);
		h.start();
		h.send({a, 1'b1}, k);
		check({7'h00, k}, 8'h01);
		h.recv(8'hFF, d);
		h.stop();
		check(d, e);
	endtask : rd

	task rx(input logic [7:0] e);
		logic k;
		logic [7:0] d;
		h.start();
		h.send(8'h4B, k);
		h.recv(8'hFF, d);
		h.stop();
		check(d, e);
	endtask : rx

	// alert poll; a missing ack ends the frame at once
	task ara(input logic [7:0] drv, input logic ea, input logic [7:0] e);
		logic k;
		logic [7:0] d;
		h.start();
		h.send(8'h19, k); // polling instead of the line
		check({7'h00, k}, {7'h00, ea});
		if (k) begin
			h.recv(drv, d);
			check(d, e);
		end
		h.stop();
	endtask : ara

	// one-cycle event pulse {pse, ovl, sta, gone, det}, then settle
	task ev(input logic [16:0] v);
		@(posedge clk_sys_i);
		#1 {power_sourcing_equipment, ovl, sta, gone, det} = v;
		@(posedge clk_sys_i);
		#1 {power_sourcing_equipment, ovl, sta, gone, det} = 17'h0;
		repeat (10) @(posedge clk_sys_i);
	endtask : ev

	// ============================================================
	// tests
	initial begin
		{power_sourcing_equipment, ovl, sta, gone, det} = 17'h0;
		// link side reset needs bus clock edges while reset is high
		fork
			repeat (20) @(posedge clk_sys_i);
			h.idle(8);
		join
		#1 rst_i = 1'b0;
		h.idle(4);
		wr(7'h25, 8'hE2, 8'hF4);
		rd(7'h25, 8'h02, 8'hF4);
		$display("test pointer access done");
		ev(17'h00001);
		check({4'h0, pwr}, 8'h01);
		check({7'h00, int_oe}, 8'h01);
		rx(8'h04);
		$display("test receive byte done");
		// a lower address wins, line must stay pulled low
		ara(8'h21, 1'b1, 8'h21);
		check({7'h00, int_oe}, 8'h01);
		ara(8'hFF, 1'b1, 8'h4B);
		check({7'h00, int_oe}, 8'h00);
		rx(8'h04);
		check({7'h00, int_oe}, 8'h00);
		ara(8'hFF, 1'b0, 8'h00);
		$display("test alert response done");
		wr(7'h25, 8'h1A, 8'h80);
		// a new event mid-frame must wait for the stop
		h.start();
		h.send(8'h4A, mid_ack);
		check({7'h00, mid_ack}, 8'h01);
		ev(17'h00002);
		check({7'h00, int_oe}, 8'h00);
		h.stop();
		repeat (10) @(posedge clk_sys_i);
		check({7'h00, int_oe}, 8'h01);
		check({4'h0, pwr}, 8'h03);
		$display("test interrupt re-arm done");
		wr(7'h30, 8'h03, 8'h02);
		ev(17'h00004);
		check({4'h0, pwr}, 8'h03);
		wr(7'h25, 8'h04, 8'h04);
		check({4'h0, pwr}, 8'h07);
		$display("test modes done");
		wr(7'h25, 8'h1A, 8'h80);
		for (int i = 0; i < 4; i++) begin
			ev(tev[i]);
			check({4'h0, pwr}, tpw[i]);
			rx(tsum[i]);
		end
		wr(7'h25, 8'h01, 8'hFF);
		rx(8'h00);
		$display("test fault reporting done");
		// manual mode: detection does not power a port, only the host turns power on
		wr(7'h25, 8'h03, 8'h01);
		rd(7'h25, 8'h03, 8'h01);
		ev(17'h00008);
		check({4'h0, pwr}, 8'h00);
		check({7'h00, int_oe}, 8'h01);
		check({7'h00, int_n}, 8'h00);
		// release bit drops the line while the cause stays
		wr(7'h25, 8'h1A, 8'h40);
		check({7'h00, int_oe}, 8'h00);
		rd(7'h25, 8'h1A, 8'h02);
		wr(7'h25, 8'h04, 8'h08);
		check({4'h0, pwr}, 8'h08);
		rd(7'h25, 8'h04, 8'h08);
		// off mode drops power and refuses host commands
		wr(7'h25, 8'h03, 8'h00);
		wr(7'h25, 8'h04, 8'h01);
		check({4'h0, pwr}, 8'h00);
		$display("test manual and off modes done");
		tally_and_finish();
	end

	// watchdog, the whole run needs well under this span
	initial begin
		#200000;
		fail_count++;
		tally_and_finish();
	end
endmodule : poe_serial_ctl_bench
